// file: dv/mss_host_model.sv
// host terminal model driving the power request and cold reset pins
`timescale 1ns/10ps
module mss_host_model
    import mss_pkg::*;
(
    input wire logic clk,
    input wire logic want_on,
    input wire logic want_reboot,
    input wire mss_pkg::mss_pins_s pins,
    output logic host_power_request,
    output logic host_cold_reset_n
);
    // both pins start released so the modem sits idle
    initial
    begin
        host_power_request = 1'b0;
        host_cold_reset_n = 1'b1;
    end
    // supply is held up all run; dropping the request is the only way off
    always @(posedge clk)
    begin
        host_power_request <= want_on;
    end
    // cold reset only once shutdown is over, since it flushes saved settings
    always @(posedge clk)
    begin
        host_cold_reset_n <= !(want_reboot && pins.dsr_n && !pins.radio_power_en);
    end
endmodule // mss_host_model

// file: dv/mss_sequencer_bench.sv
// self-checking bench for the shutdown sequencer
`timescale 1ns/10ps
`include "mss_map.svh"
module mss_sequencer_bench;
    import mss_pkg::*;
    localparam logic [1:0] r_ok = `MSS_RESP_OKAY;
    localparam logic [1:0] r_err = `MSS_RESP_SLVERR;
    logic clk;
    logic arst_n;
    logic want_on;
    logic want_reboot;
    logic host_power_request;
    logic host_cold_reset_n;
    mss_axil_req_s rq;
    mss_axil_rsp_s rs;
    mss_pins_s pn;
    logic [33:0] exp_q[$];
    logic [31:0] live;
    integer seed;
    int err_total;
    int comparisons;
    int k;
    ////////////////////
    // short tick so a step of 250 ticks is 2500 cycles
    mss_sequencer #(.TICK_CYCLES(10)) DUT (.clk(clk), .arst_n(arst_n),
        .host_power_request(host_power_request), .host_cold_reset_n(host_cold_reset_n),
        .axil_req(rq), .axil_rsp(rs), .pins(pn));
    mss_host_model host (.clk(clk), .want_on(want_on), .want_reboot(want_reboot),
        .pins(pn), .host_power_request(host_power_request),
        .host_cold_reset_n(host_cold_reset_n));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////
    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        comparisons++;
        if (seen !== want)
        begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, seen, want);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // a wait that ran out counts as a mismatch and ends the run
    task automatic hang(input int n, input int lim);
        if (n >= lim)
        begin
            err_total++;
            $display("[ERR] %0t wait ran out", $time);
            complete_run();
        end
    endtask
    // one bus access: note the answer, offer, release each channel when taken
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r);
        int n;
        @(posedge clk);
        exp_q.push_back({r, w ? 32'h0 : d});
        rq.awaddr <= a;
        rq.araddr <= a;
        rq.wdata <= d;
        rq.awvalid <= w;
        rq.wvalid <= w;
        rq.bready <= w;
        rq.arvalid <= !w;
        rq.rready <= !w;
        for (n = 0; n < 50 && !(rs.bvalid && rq.bready || rs.rvalid && rq.rready); n++)
        begin
            @(posedge clk);
            if (rs.awready)
                rq.awvalid <= 1'b0;
            if (rs.wready)
                rq.wvalid <= 1'b0;
            if (rs.arready)
                rq.arvalid <= 1'b0;
        end
        rq.bready <= 1'b0;
        rq.rready <= 1'b0;
        hang(n, 50);
    endtask
    // watcher: every answer taken on the bus is judged against the oldest note
    always @(posedge clk)
    begin
        if (rs.bvalid && rq.bready)
            check({rs.bresp, 32'h0}, exp_q.pop_front());
        if (rs.rvalid && rq.rready)
            check({rs.rresp, rs.rdata}, exp_q.pop_front());
    end
    ////////////////////
    initial
    begin
        rq = '0;
        rq.wstrb = 4'hF;
        arst_n = 1'b0;
        want_on = 1'b0;
        want_reboot = 1'b0;
        seed = 32'h8DCC5E12;
        live = $random(seed);
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        // let the pin synchronisers settle before the first access
        repeat (8) @(posedge clk);
        bus(0, `MSS_REG_STEP, {16'h0, `MSS_STEP_RESET}, r_ok);
        bus(0, 8'h14, 32'h0, r_err);
        bus(1, 8'h14, live, r_err);
        bus(1, `MSS_REG_STEP, 32'hFFFF, r_ok);
        bus(0, `MSS_REG_STEP, {16'h0, `MSS_STEP_MAX}, r_ok);
        bus(1, `MSS_REG_STEP, 32'hFA, r_ok);
        bus(1, `MSS_REG_LIVE, live, r_ok);
        $display("-- registers done");
        want_on <= 1'b1;
        for (k = 0; k < 40 && pn.radio_power_en !== 1'b1; k++)
            @(posedge clk);
        hang(k, 40);
        repeat (2) @(posedge clk);
        check(34'({pn.dsr_n, pn.dcd_n}), 34'(2'b00));
        // serial request alone must not start the shutdown
        bus(1, `MSS_REG_CTRL, 32'h1, r_ok);
        repeat (20) @(posedge clk);
        bus(0, `MSS_REG_STATUS, 32'h19, r_ok);
        bus(0, `MSS_REG_CTRL, 32'h1, r_ok);
        $display("-- power on done");
        want_on <= 1'b0;
        repeat (10) @(posedge clk);
        check(34'({pn.dcd_n, pn.dsr_n}), 34'(2'b10));
        for (k = 0; k < 1500 && pn.battery_led_n !== 1'b0; k++)
            @(posedge clk);
        hang(k, 1500);
        check(34'({pn.dsr_n, pn.radio_power_en}), 34'(2'b01));
        for (k = 0; k < 6000 && pn.dsr_n !== 1'b1; k++)
            @(posedge clk);
        hang(k, 6000);
        repeat (4) @(posedge clk);
        check(34'({pn.radio_power_en, pn.battery_led_n}), 34'(2'b01));
        bus(0, `MSS_REG_SAVED, live, r_ok);
        bus(0, `MSS_REG_CTRL, 32'h0, r_ok);
        repeat (200) @(posedge clk);
        bus(0, `MSS_REG_STATUS, 32'hE0, r_ok);
        $display("-- shutdown done");
        want_reboot <= 1'b1;
        repeat (12) @(posedge clk);
        bus(0, `MSS_REG_STATUS, 32'h66, r_ok);
        want_reboot <= 1'b0;
        for (k = 0; k < 20 && pn.cold_start !== 1'b1; k++)
            @(posedge clk);
        hang(k, 20);
        bus(0, `MSS_REG_STATUS, 32'h60, r_ok);
        bus(0, `MSS_REG_SAVED, 32'h0, r_ok);
        $display("-- cold reboot done");
        complete_run();
    end
endmodule // mss_sequencer_bench

// file: dv/mss_sequencer_checker.sv
// port assertions for the shutdown sequencer
`timescale 1ns/10ps
module mss_sequencer_checker
    import mss_pkg::*;
#(
    parameter int TICK_CYCLES = 10
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic host_power_request,
    input wire logic host_cold_reset_n,
    input wire mss_pkg::mss_axil_req_s axil_req,
    input wire mss_pkg::mss_axil_rsp_s axil_rsp,
    input wire mss_pkg::mss_pins_s pins
);
    ////////////////////
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    ////////////////////
    // pin order; a cold reset may raise several lines at once
    a_dereg_start: assert property ((host_cold_reset_n && !host_power_request) [*6]
        |-> pins.dcd_n) else $error("no deregistration");
    a_dsr_order: assert property ($rose(pins.dsr_n) |-> pins.dcd_n)
        else $error("ready before carrier");
    a_rail_order: assert property ($fell(pins.radio_power_en) |-> pins.dsr_n)
        else $error("rail off while ready");
    a_led_blink: assert property ($fell(pins.battery_led_n)
        |-> pins.dcd_n && !pins.dsr_n && pins.radio_power_en) else $error("stray blink");
    a_cold_force: assert property (!host_cold_reset_n [*6]
        |-> !pins.radio_power_en && pins.dsr_n && pins.dcd_n) else $error("cold ignored");
    a_cold_pulse: assert property (pins.cold_start |=> !pins.cold_start)
        else $error("long cold pulse");
    a_ready_req: assert property ($fell(pins.dsr_n) |-> host_power_request)
        else $error("ready unrequested");
    // bus answers: read one cycle after the address, write two after both channels
    a_read_answer: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
        else $error("late read");
    a_write_answer: assert property (axil_req.awvalid && axil_rsp.awready
        && axil_req.wvalid && axil_rsp.wready |-> ##2 axil_rsp.bvalid)
        else $error("late write answer");
    c_blink: cover property ($fell(pins.battery_led_n));
    c_ready_drop: cover property ($rose(pins.dsr_n));
    c_cold: cover property (pins.cold_start);
endmodule // mss_sequencer_checker

bind mss_sequencer mss_sequencer_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.clk(clk),
    .arst_n(arst_n), .host_power_request(host_power_request),
    .host_cold_reset_n(host_cold_reset_n), .axil_req(axil_req),
    .axil_rsp(axil_rsp), .pins(pins));

// file: hdl/mss_map.svh
// register offsets, field positions, reset values and timing counts of the sequencer
`ifndef MSS_MAP_SVH
`define MSS_MAP_SVH
`define MSS_REG_CTRL 8'h00
`define MSS_REG_STATUS 8'h04
`define MSS_REG_STEP 8'h08
`define MSS_REG_SAVED 8'h0C
`define MSS_REG_LIVE 8'h10
`define MSS_CTRL_SERIAL_REQ 0
`define MSS_SYNC_IDLE 2'b10
`define MSS_STEP_RESET 16'h03E8
`define MSS_STEP_MAX 16'h1387
`define MSS_LED_HALF_MS 16'h0064
`define MSS_CLK_PERIOD_NS 10
`define MSS_TICK_NS 1000000
`define MSS_TICK_CYCLES (`MSS_TICK_NS / `MSS_CLK_PERIOD_NS)
`define MSS_RESP_OKAY 2'b00
`define MSS_RESP_SLVERR 2'b10
`endif

// file: hdl/mss_pkg.sv
// types shared by the soft shutdown sequencer
package mss_pkg;
    typedef enum logic [2:0] {
        MSS_ST_OFF = 3'b000,
        MSS_ST_ON = 3'b001,
        MSS_ST_DEREG = 3'b010,
        MSS_ST_SAVE = 3'b011,
        MSS_ST_READY_DROP = 3'b100,
        MSS_ST_RAIL_OFF = 3'b101,
        MSS_ST_COLD = 3'b110
    } mss_state_e;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } mss_axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mss_axil_rsp_s;

    typedef struct packed {
        logic dcd_n;
        logic dsr_n;
        logic radio_power_en;
        logic battery_led_n;
        logic cold_start;
    } mss_pins_s;
endpackage

// file: hdl/mss_sequencer.sv
// soft shutdown sequencer for a data modem, with an AXI4-Lite register slave
// Operation
// [RQ1] host withdraws power request, or sends serial shutdown then withdraws request
// [RQ2] shutdown starts when synchronised power request is seen low
// [RQ3] deregister, drop carrier detect, save configuration, then drop ready
// [RQ4] host keeps supply up to ten seconds, typically two, after withdrawal
// [RQ5] after deregistration the internal radio power enable is withdrawn
// [RQ6] battery indicator blinks fast during shutdown steps, stops when done
// [RQ7] saved settings survive; idle with request withdrawn is a stable state
// [RQ8] host may assert cold reset after shutdown, only to reboot
// [RQ9] cold reset flushes saved settings and gives a cold start on release
// [RQ10] cold reset, ready, carrier detect and indicator are active low
// [RQ11] modem turns on when power request is asserted
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "mss_map.svh"
module mss_sequencer #(
    parameter int TICK_CYCLES = `MSS_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic host_power_request,
    input wire logic host_cold_reset_n,
    input wire mss_pkg::mss_axil_req_s axil_req,
    output mss_pkg::mss_axil_rsp_s axil_rsp,
    output mss_pkg::mss_pins_s pins
);
    import mss_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] pin_raw;
    logic request_s;
    logic cold_n_s;
    assign pin_raw = {host_cold_reset_n, host_power_request};
    // flops reset to each pin's idle level, so no false cold reset follows reset
    localparam logic [1:0] SYNC_IDLE = `MSS_SYNC_IDLE;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync
            // first stage feeds only the second stage
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    sync_a[gi] <= SYNC_IDLE[gi];
                    sync_b[gi] <= SYNC_IDLE[gi];
                end
                else
                begin
                    sync_a[gi] <= pin_raw[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate
    assign request_s = sync_b[0];
    assign cold_n_s = sync_b[1]; // RQ10

    ////////////////////////////////////////////////////////////////////////////////
    // millisecond enable
    logic ms_tick;
    mss_tick #(
        .DIV(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .arst_n(arst_n),
        .tick(ms_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // registers and sequencer state
    mss_state_e state;
    logic [15:0] step_ms;
    logic [31:0] next_step;
    logic [15:0] step_cnt;
    logic [15:0] led_cnt;
    logic [31:0] live_cfg;
    logic [31:0] saved_cfg;
    logic saved_valid;
    logic serial_req;
    logic step_done;
    logic in_shutdown;
    logic cold_seen;
    assign step_done = ms_tick && (step_cnt >= step_ms);
    assign in_shutdown = (state == MSS_ST_DEREG) || (state == MSS_ST_SAVE);

    // write side of the bus: address and data latched independently
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    assign wr_fire = aw_held && w_held && !axil_rsp.bvalid;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == `MSS_REG_CTRL) || (a == `MSS_REG_STATUS) || (a == `MSS_REG_STEP)
            || (a == `MSS_REG_SAVED) || (a == `MSS_REG_LIVE);
    endfunction

    // write address and data channels
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            axil_rsp.awready <= 1'b0;
            axil_rsp.wready <= 1'b0;
        end
        else
        begin
            axil_rsp.awready <= !aw_held && !(axil_req.awvalid && axil_rsp.awready);
            axil_rsp.wready <= !w_held && !(axil_req.wvalid && axil_rsp.wready);
            if (axil_req.awvalid && axil_rsp.awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= axil_req.awaddr;
            end
            else if (wr_fire)
            begin
                aw_held <= 1'b0;
            end
            if (axil_req.wvalid && axil_rsp.wready)
            begin
                w_held <= 1'b1;
                w_data <= axil_req.wdata;
                w_strb <= axil_req.wstrb;
            end
            else if (wr_fire)
            begin
                w_held <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            axil_rsp.bvalid <= 1'b0;
            axil_rsp.bresp <= `MSS_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            axil_rsp.bvalid <= 1'b1;
            axil_rsp.bresp <= is_mapped(aw_addr) ? `MSS_RESP_OKAY : `MSS_RESP_SLVERR;
        end
        else if (axil_req.bready)
        begin
            axil_rsp.bvalid <= 1'b0;
        end
    end

    // software-written settings; step time is clamped so two steps stay within ten seconds
    assign next_step = merge({16'h0000, step_ms}, w_data, w_strb);
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            step_ms <= `MSS_STEP_RESET;
            live_cfg <= 32'h0000_0000;
        end
        else if (wr_fire && aw_addr == `MSS_REG_STEP)
        begin
            step_ms <= (next_step > 32'(`MSS_STEP_MAX))
                ? `MSS_STEP_MAX : next_step[15:0]; // RQ4
        end
        else if (wr_fire && aw_addr == `MSS_REG_LIVE)
        begin
            live_cfg <= merge(live_cfg, w_data, w_strb);
        end
    end

    // serial shutdown request: only a flag, the pin must still fall
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            serial_req <= 1'b0;
        end
        else if (state == MSS_ST_DEREG)
        begin
            serial_req <= 1'b0; // RQ1
        end
        else if (wr_fire && aw_addr == `MSS_REG_CTRL && w_strb[0])
        begin
            serial_req <= w_data[`MSS_CTRL_SERIAL_REQ];
        end
    end

    // read channel, one read under way at a time
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            axil_rsp.arready <= 1'b0;
            axil_rsp.rvalid <= 1'b0;
            axil_rsp.rdata <= 32'h0000_0000;
            axil_rsp.rresp <= `MSS_RESP_OKAY;
        end
        else if (axil_req.arvalid && axil_rsp.arready)
        begin
            axil_rsp.arready <= 1'b0;
            axil_rsp.rvalid <= 1'b1;
            axil_rsp.rresp <= is_mapped(axil_req.araddr) ? `MSS_RESP_OKAY : `MSS_RESP_SLVERR;
            unique case (axil_req.araddr)
                `MSS_REG_CTRL: axil_rsp.rdata <= {31'h0000_0000, serial_req};
                `MSS_REG_STATUS: axil_rsp.rdata <= {24'h00_0000, saved_valid, pins.dcd_n,
                    pins.dsr_n, pins.radio_power_en, request_s, state};
                `MSS_REG_STEP: axil_rsp.rdata <= {16'h0000, step_ms};
                `MSS_REG_SAVED: axil_rsp.rdata <= saved_cfg;
                `MSS_REG_LIVE: axil_rsp.rdata <= live_cfg;
                default: axil_rsp.rdata <= 32'h0000_0000;
            endcase
        end
        else if (axil_rsp.rvalid)
        begin
            if (axil_req.rready)
            begin
                axil_rsp.rvalid <= 1'b0;
            end
        end
        else
        begin
            axil_rsp.arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power sequence; cold reset overrides every state
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= MSS_ST_OFF;
        end
        else if (!cold_n_s)
        begin
            state <= MSS_ST_COLD; // RQ9
        end
        else
        begin
            unique case (state)
                MSS_ST_OFF: if (request_s) state <= MSS_ST_ON; // RQ11 RQ7
                MSS_ST_ON: if (!request_s) state <= MSS_ST_DEREG; // RQ2
                MSS_ST_DEREG: if (step_done) state <= MSS_ST_SAVE; // RQ3
                MSS_ST_SAVE: if (step_done) state <= MSS_ST_READY_DROP; // RQ3
                MSS_ST_READY_DROP: state <= MSS_ST_RAIL_OFF;
                MSS_ST_RAIL_OFF: state <= MSS_ST_OFF; // RQ5
                MSS_ST_COLD: state <= MSS_ST_OFF;
                default: state <= MSS_ST_OFF;
            endcase
        end
    end

    // step timer restarts at each state change
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            step_cnt <= 16'h0000;
        end
        else if (!in_shutdown || step_done)
        begin
            step_cnt <= 16'h0000;
        end
        else if (ms_tick)
        begin
            step_cnt <= step_cnt + 16'h0001;
        end
    end

    // saved settings: written during the save step, flushed by cold reset
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            saved_cfg <= 32'h0000_0000;
            saved_valid <= 1'b0;
        end
        else if (state == MSS_ST_COLD)
        begin
            saved_cfg <= 32'h0000_0000; // RQ9
            saved_valid <= 1'b0;
        end
        else if (state == MSS_ST_SAVE && step_done)
        begin
            saved_cfg <= live_cfg; // RQ3 RQ7
            saved_valid <= 1'b1;
        end
    end

    // modem status pins, all active low except the rail enable
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pins.dcd_n <= 1'b1;
            pins.dsr_n <= 1'b1;
            pins.radio_power_en <= 1'b0;
        end
        else
        begin
            pins.radio_power_en <= (state == MSS_ST_ON) || in_shutdown
                || (state == MSS_ST_READY_DROP); // RQ5
            pins.dcd_n <= (state != MSS_ST_ON); // RQ3 RQ10
            pins.dsr_n <= !((state == MSS_ST_ON) || in_shutdown); // RQ3 RQ10
        end
    end

    // indicator blinks only while shutdown steps run
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            led_cnt <= 16'h0000;
            pins.battery_led_n <= 1'b1;
        end
        else if (!in_shutdown)
        begin
            led_cnt <= 16'h0000;
            pins.battery_led_n <= 1'b1; // RQ6 RQ10
        end
        else if (ms_tick)
        begin
            if (led_cnt >= `MSS_LED_HALF_MS - 16'h0001)
            begin
                led_cnt <= 16'h0000;
                pins.battery_led_n <= !pins.battery_led_n; // RQ6
            end
            else
            begin
                led_cnt <= led_cnt + 16'h0001;
            end
        end
    end

    // one-cycle cold start pulse when the cold reset line is released
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cold_seen <= 1'b0;
            pins.cold_start <= 1'b0;
        end
        else
        begin
            cold_seen <= (state == MSS_ST_COLD) && !cold_n_s;
            pins.cold_start <= cold_seen && cold_n_s; // RQ9
        end
    end
endmodule // mss_sequencer

// file: hdl/mss_tick.sv
// divider that gives a one-cycle enable pulse every DIV clocks
`timescale 1ns/10ps
module mss_tick #(
    parameter int DIV = 100000
) (
    input wire logic clk,
    input wire logic arst_n,
    output logic tick
);
    logic [31:0] count;

    // free-running count; the pulse is one cycle wide
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count <= 32'h0000_0000;
            tick <= 1'b0;
        end
        else if (count >= 32'(DIV - 1))
        begin
            count <= 32'h0000_0000;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule // mss_tick
